// ===== hw/bus_info_block_regs.sv
/*
  bus identification and bus options words of the bus information block.
  assumes a single-cycle register port (read data one cycle after the read strobe),
  an asynchronous hard reset and a synchronous soft reset pulse on i_clk.
*/
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
module bus_info_block_regs
  import bus_info_pkg::*;
(
  input  wire logic                  i_clk,
  input  wire logic                  i_reset,
  input  wire logic                  i_soft_reset,
  input  wire logic [REG_ADDR_W-1:0] i_addr,
  input  wire logic [31:0]           i_wdata,
  input  wire logic                  i_write,
  input  wire logic                  i_read,
  input  wire logic                  i_link_active_control,
  input  wire logic                  i_blk_wr_valid,
  input  wire logic [15:0]           i_blk_wr_len,
  output logic [31:0]                o_rdata,
  output logic [31:0]                o_bus_id_quadlet,
  output logic [31:0]                o_bus_options_quadlet,
  output logic [15:0]                o_max_rec_bytes,
  output logic                       o_blk_wr_too_long,
  output logic                       o_rec_code_invalid
);

  logic [4:0]  cap_flags;
  logic [7:0]  clk_accuracy;
  logic [3:0]  rec_code;
  logic [1:0]  gen_tally;
  logic [31:0] options_word;
  logic [15:0] next_max_bytes;
  logic        opt_write;

  assign opt_write = i_write && (i_addr == BUS_OPTIONS_OFFSET);

  // reserved ranges are constant zero, speed code fixed
  always_comb begin
    options_word                 = '0;
    options_word[CAP_HI:CAP_LO]  = cap_flags;
    options_word[ACC_HI:ACC_LO]  = clk_accuracy;
    options_word[REC_HI:REC_LO]  = rec_code;
    options_word[GEN_HI:GEN_LO]  = gen_tally;
    options_word[SPD_HI:SPD_LO]  = LINK_SPEED_CODE;
  end

  // codes above 14 would overflow 16 bits; saturate to the top value
  always_comb begin
    if (rec_code >= 4'hf) begin
      next_max_bytes = 16'hffff;
    end else begin
      next_max_bytes = 16'(17'h0_0002 << rec_code);
    end
  end

  // software fields; soft reset clears the option flags but not the size code
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      cap_flags    <= CAP_RESET;
      clk_accuracy <= ACC_RESET;
      gen_tally    <= GEN_RESET;
    end else if (i_soft_reset) begin
      cap_flags    <= CAP_RESET;
      clk_accuracy <= ACC_RESET;
      gen_tally    <= GEN_RESET;
    end else if (opt_write) begin
      cap_flags    <= i_wdata[CAP_HI:CAP_LO];
      clk_accuracy <= i_wdata[ACC_HI:ACC_LO];
      gen_tally    <= i_wdata[GEN_HI:GEN_LO];
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      rec_code <= REC_RESET;
    end else if (opt_write) begin
      rec_code <= i_wdata[REC_HI:REC_LO];
    end
  end

  // read port; unmapped offsets read zero, bus id is a constant
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_rdata <= '0;
    end else if (i_read) begin
      if (i_addr == BUS_ID_OFFSET) begin
        o_rdata <= BUS_ID_VALUE;
      end else if (i_addr == BUS_OPTIONS_OFFSET) begin
        o_rdata <= options_word;
      end else begin
        o_rdata <= '0;
      end
    end else begin
      o_rdata <= '0;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_bus_id_quadlet      <= BUS_ID_VALUE;
      // outer quadlet shows the reset word, so the speed code is never missing
      o_bus_options_quadlet <= {CAP_RESET, 3'h0, ACC_RESET, REC_RESET, 4'h0, GEN_RESET, 3'h0,
                                LINK_SPEED_CODE};
      o_max_rec_bytes       <= 16'(17'h0_0002 << REC_RESET);
      o_rec_code_invalid    <= 1'b0;
    end else begin
      o_bus_id_quadlet      <= BUS_ID_VALUE;
      o_bus_options_quadlet <= options_word;
      o_max_rec_bytes       <= next_max_bytes;
      o_rec_code_invalid    <= i_link_active_control && (rec_code < REC_MIN_CODE);
    end
  end

  // flag is a hint to the receive logic, which decides whether to ack with a type error
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_blk_wr_too_long <= 1'b0;
    end else begin
      o_blk_wr_too_long <= i_blk_wr_valid && (i_blk_wr_len > next_max_bytes);
    end
  end

  property p_bus_id_read;
    @(posedge i_clk) disable iff (i_reset)
      (i_read && i_addr == BUS_ID_OFFSET) |=> (o_rdata == 32'h3133_3934);
  endproperty
  a_bus_id_read: assert property (p_bus_id_read) else $error("bus id read wrong");

  property p_opt_read;
    @(posedge i_clk) disable iff (i_reset)
      (i_read && i_addr == BUS_OPTIONS_OFFSET) |=> (o_rdata == o_bus_options_quadlet);
  endproperty
  a_opt_read: assert property (p_opt_read) else $error("options read mismatch");

  property p_reserved_zero;
    @(posedge i_clk) disable iff (i_reset)
      (i_read && i_addr == BUS_OPTIONS_OFFSET) |=>
      (o_rdata[26:24] == 3'h0) && (o_rdata[11:8] == 4'h0) && (o_rdata[5:3] == 3'h0);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");

  property p_max_bytes;
    @(posedge i_clk) disable iff (i_reset)
      (rec_code == 4'h8) |=> (o_max_rec_bytes == 16'h0200);
  endproperty
  a_max_bytes: assert property (p_max_bytes) else $error("max bytes wrong");

  property p_hard_default;
    @(posedge i_clk) $fell(i_reset) |-> (rec_code == 4'ha);
  endproperty
  a_hard_default: assert property (p_hard_default) else $error("size code default");

  property p_soft_keeps;
    @(posedge i_clk) disable iff (i_reset)
      (i_soft_reset && !opt_write) |=> (rec_code == $past(rec_code));
  endproperty
  a_soft_keeps: assert property (p_soft_keeps) else $error("soft reset hit size code");

  property p_too_long;
    @(posedge i_clk) disable iff (i_reset)
      (i_blk_wr_valid && i_blk_wr_len > next_max_bytes) |=> o_blk_wr_too_long;
  endproperty
  a_too_long: assert property (p_too_long) else $error("long write not flagged");

  property p_speed;
    @(posedge i_clk) disable iff (i_reset)
      ##1 (o_bus_options_quadlet[2:0] == 3'h2);
  endproperty
  a_speed: assert property (p_speed) else $error("speed code wrong");

  property p_ro_ignored;
    @(posedge i_clk) disable iff (i_reset)
      (i_write && i_addr == BUS_ID_OFFSET) ##1 (i_read && i_addr == BUS_ID_OFFSET)
      |=> (o_rdata == BUS_ID_VALUE);
  endproperty
  a_ro_ignored: assert property (p_ro_ignored) else $error("bus id changed");

  // read data stand one cycle only; other offsets read zero
  property p_rdata_idle;
    @(posedge i_clk) disable iff (i_reset)
      !i_read |=> (o_rdata == 32'h0000_0000);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data when idle");

  property p_unmapped_read;
    @(posedge i_clk) disable iff (i_reset)
      (i_read && i_addr != BUS_ID_OFFSET && i_addr != BUS_OPTIONS_OFFSET) |=>
      (o_rdata == 32'h0000_0000);
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("stray read data");

  property p_opt_fields_read;
    @(posedge i_clk) disable iff (i_reset)
      (i_read && i_addr == BUS_OPTIONS_OFFSET) |=>
      (o_rdata[CAP_HI:CAP_LO] == $past(cap_flags)) &&
      (o_rdata[ACC_HI:ACC_LO] == $past(clk_accuracy)) &&
      (o_rdata[REC_HI:REC_LO] == $past(rec_code)) &&
      (o_rdata[GEN_HI:GEN_LO] == $past(gen_tally));
  endproperty
  a_opt_fields_read: assert property (p_opt_fields_read) else $error("options field read");

  property p_read_speed;
    @(posedge i_clk) disable iff (i_reset)
      (i_read && i_addr == BUS_OPTIONS_OFFSET) |=> (o_rdata[SPD_HI:SPD_LO] == 3'h2);
  endproperty
  a_read_speed: assert property (p_read_speed) else $error("speed code read");

  // outer quadlets hold at every cycle outside hard reset
  property p_bus_id_quadlet;
    @(posedge i_clk) disable iff (i_reset)
      (o_bus_id_quadlet == 32'h3133_3934);
  endproperty
  a_bus_id_quadlet: assert property (p_bus_id_quadlet) else $error("bus id quadlet");

  property p_quadlet_reserved;
    @(posedge i_clk) disable iff (i_reset)
      (o_bus_options_quadlet[26:24] == 3'h0) && (o_bus_options_quadlet[11:8] == 4'h0) &&
      (o_bus_options_quadlet[5:3] == 3'h0);
  endproperty
  a_quadlet_reserved: assert property (p_quadlet_reserved) else $error("quadlet reserved");

  property p_quadlet_fields;
    @(posedge i_clk) disable iff (i_reset)
      1'b1 |=> (o_bus_options_quadlet[CAP_HI:CAP_LO] == $past(cap_flags)) &&
               (o_bus_options_quadlet[ACC_HI:ACC_LO] == $past(clk_accuracy)) &&
               (o_bus_options_quadlet[REC_HI:REC_LO] == $past(rec_code)) &&
               (o_bus_options_quadlet[GEN_HI:GEN_LO] == $past(gen_tally));
  endproperty
  a_quadlet_fields: assert property (p_quadlet_fields) else $error("quadlet fields");

  // size code moves only on a write, soft reset or not
  property p_rec_write;
    @(posedge i_clk) disable iff (i_reset)
      opt_write |=> (rec_code == $past(i_wdata[REC_HI:REC_LO]));
  endproperty
  a_rec_write: assert property (p_rec_write) else $error("size code write");

  property p_rec_hold;
    @(posedge i_clk) disable iff (i_reset)
      !opt_write |=> (rec_code == $past(rec_code));
  endproperty
  a_rec_hold: assert property (p_rec_hold) else $error("size code moved");

  property p_soft_clears;
    @(posedge i_clk) disable iff (i_reset)
      i_soft_reset |=> (cap_flags == CAP_RESET) && (clk_accuracy == ACC_RESET) &&
                       (gen_tally == GEN_RESET);
  endproperty
  a_soft_clears: assert property (p_soft_clears) else $error("soft reset fields");

  property p_write_lands;
    @(posedge i_clk) disable iff (i_reset)
      (opt_write && !i_soft_reset) |=>
      (cap_flags == $past(i_wdata[CAP_HI:CAP_LO])) &&
      (clk_accuracy == $past(i_wdata[ACC_HI:ACC_LO])) &&
      (gen_tally == $past(i_wdata[GEN_HI:GEN_LO]));
  endproperty
  a_write_lands: assert property (p_write_lands) else $error("options write lost");

  property p_max_bytes_zero;
    @(posedge i_clk) disable iff (i_reset)
      (rec_code == 4'h0) |=> (o_max_rec_bytes == 16'h0002);
  endproperty
  a_max_bytes_zero: assert property (p_max_bytes_zero) else $error("max bytes code 0");

  property p_max_bytes_top;
    @(posedge i_clk) disable iff (i_reset)
      (rec_code == 4'hf) |=> (o_max_rec_bytes == 16'hffff);
  endproperty
  a_max_bytes_top: assert property (p_max_bytes_top) else $error("max bytes code 15");

  property p_max_bytes_default;
    @(posedge i_clk) disable iff (i_reset)
      (rec_code == 4'ha) |=> (o_max_rec_bytes == 16'h0800);
  endproperty
  a_max_bytes_default: assert property (p_max_bytes_default) else $error("max bytes 2048");

  property p_hard_outputs;
    @(posedge i_clk) $fell(i_reset) |->
      (o_max_rec_bytes == 16'h0800) && (o_bus_options_quadlet[REC_HI:REC_LO] == 4'ha);
  endproperty
  a_hard_outputs: assert property (p_hard_outputs) else $error("outputs after reset");

  // status flags follow their inputs one cycle later
  property p_no_flag;
    @(posedge i_clk) disable iff (i_reset)
      !(i_blk_wr_valid && i_blk_wr_len > next_max_bytes) |=> !o_blk_wr_too_long;
  endproperty
  a_no_flag: assert property (p_no_flag) else $error("false long write flag");

  property p_code_invalid;
    @(posedge i_clk) disable iff (i_reset)
      (i_link_active_control && rec_code < 4'h8) |=> o_rec_code_invalid;
  endproperty
  a_code_invalid: assert property (p_code_invalid) else $error("small code missed");

  property p_code_valid;
    @(posedge i_clk) disable iff (i_reset)
      (!i_link_active_control || rec_code >= 4'h8) |=> !o_rec_code_invalid;
  endproperty
  a_code_valid: assert property (p_code_valid) else $error("false small code");

  c_opt_write: cover property (@(posedge i_clk) disable iff (i_reset) opt_write);
  c_id_read: cover property (@(posedge i_clk) disable iff (i_reset)
    i_read && i_addr == BUS_ID_OFFSET);
  c_too_long: cover property (@(posedge i_clk) disable iff (i_reset) o_blk_wr_too_long);
  c_soft: cover property (@(posedge i_clk) disable iff (i_reset) i_soft_reset);
  c_soft_write: cover property (@(posedge i_clk) disable iff (i_reset)
    i_soft_reset && opt_write);

endmodule

// ===== hw/bus_info_pkg.sv
/*
  constants for the bus information block registers: offsets, field positions,
  reset values and fixed codes. assumes a 32-bit register port with byte offsets.
*/
package bus_info_pkg;

  localparam int          REG_ADDR_W         = 8;
  localparam logic [7:0]  BUS_ID_OFFSET      = 8'h1c;
  localparam logic [7:0]  BUS_OPTIONS_OFFSET = 8'h20;
  localparam logic [31:0] BUS_ID_VALUE       = 32'h3133_3934;

  localparam int          CAP_HI             = 31;
  localparam int          CAP_LO             = 27;
  localparam int          ACC_HI             = 23;
  localparam int          ACC_LO             = 16;
  localparam int          REC_HI             = 15;
  localparam int          REC_LO             = 12;
  localparam int          GEN_HI             = 7;
  localparam int          GEN_LO             = 6;
  localparam int          SPD_HI             = 2;
  localparam int          SPD_LO             = 0;

  localparam logic [4:0]  CAP_RESET          = 5'h00;
  localparam logic [7:0]  ACC_RESET          = 8'h00;
  localparam logic [3:0]  REC_RESET          = 4'ha;
  localparam logic [1:0]  GEN_RESET          = 2'h0;
  localparam logic [2:0]  LINK_SPEED_CODE    = 3'h2;
  localparam logic [3:0]  REC_MIN_CODE       = 4'h8;

endpackage

// ===== test/bus_info_block_regs_tb.sv
/*
  self-checking bench for the bus information block registers.
  assumes the single-cycle register port: read data stand in the cycle after the read strobe.
*/
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin n_mismatch++; \
  $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module bus_info_block_regs_tb import bus_info_pkg::*;;
  logic                  i_clk = 1'b0;
  logic                  i_reset = 1'b1;
  logic                  i_soft_reset = 1'b0;
  logic [REG_ADDR_W-1:0] i_addr = '0;
  logic [31:0]           i_wdata = '0;
  logic                  i_write = 1'b0;
  logic                  i_read = 1'b0;
  logic                  i_link_active_control = 1'b0;
  logic                  i_blk_wr_valid = 1'b0;
  logic [15:0]           i_blk_wr_len = '0;
  logic [31:0]           o_rdata;
  logic [31:0]           o_bus_id_quadlet;
  logic [31:0]           o_bus_options_quadlet;
  logic [15:0]           o_max_rec_bytes;
  logic                  o_blk_wr_too_long;
  logic                  o_rec_code_invalid;
  int                    n_mismatch = 0;
  int                    comparisons = 0;
  logic [15:0]           lim;

  always #2 i_clk = ~i_clk;

  bus_info_block_regs dut (.i_clk(i_clk), .i_reset(i_reset), .i_soft_reset(i_soft_reset),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_write(i_write), .i_read(i_read),
    .i_link_active_control(i_link_active_control), .i_blk_wr_valid(i_blk_wr_valid),
    .i_blk_wr_len(i_blk_wr_len), .o_rdata(o_rdata), .o_bus_id_quadlet(o_bus_id_quadlet),
    .o_bus_options_quadlet(o_bus_options_quadlet), .o_max_rec_bytes(o_max_rec_bytes),
    .o_blk_wr_too_long(o_blk_wr_too_long), .o_rec_code_invalid(o_rec_code_invalid));

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_write <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_write <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ex);
    @(posedge i_clk);
    i_read <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_read <= 1'b0;
    #1 `CHK("rdata", ex, o_rdata)
  endtask

  task automatic blk(input logic [15:0] len, input logic ex);
    @(posedge i_clk);
    i_blk_wr_valid <= 1'b1;
    i_blk_wr_len   <= len;
    @(posedge i_clk);
    i_blk_wr_valid <= 1'b0;
    #1 `CHK("too_long", ex, o_blk_wr_too_long)
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge i_clk);
    i_reset <= 1'b0;
    rd(8'h1c, 32'h3133_3934);
    rd(8'h20, 32'h0000_a002);
    `CHK("max_bytes", 16'h0800, o_max_rec_bytes)
    `CHK("id_quadlet", 32'h3133_3934, o_bus_id_quadlet)
    // all ones: only writable fields may stick
    wr(8'h20, 32'hffff_ffff);
    wr(8'h1c, 32'h0000_0000);
    rd(8'h20, 32'hf8ff_f0c2);
    `CHK("opt_quadlet", 32'hf8ff_f0c2, o_bus_options_quadlet)
    rd(8'h1c, 32'h3133_3934);
    rd(8'h24, 32'h0000_0000);
    // soft reset must not disturb the size code
    @(posedge i_clk);
    i_soft_reset <= 1'b1;
    @(posedge i_clk);
    i_soft_reset <= 1'b0;
    rd(8'h20, 32'h0000_f002);
    // soft reset beside a write: only the size code takes the write
    @(posedge i_clk);
    i_soft_reset <= 1'b1;
    i_write      <= 1'b1;
    i_addr       <= 8'h20;
    i_wdata      <= 32'hffff_9fff;
    @(posedge i_clk);
    i_soft_reset <= 1'b0;
    i_write      <= 1'b0;
    rd(8'h20, 32'h0000_9002);
    @(posedge i_clk);
    i_link_active_control <= 1'b1;
    for (int c = 0; c < 16; c++) begin
      wr(8'h20, {16'h0000, c[3:0], 12'h000});
      repeat (2) @(posedge i_clk);
      lim = (c == 15) ? 16'hffff : 16'(32'h1 << (c + 1));
      #1 `CHK("max_bytes", lim, o_max_rec_bytes)
      `CHK("code_invalid", (c < 8), o_rec_code_invalid)
      if (c < 15) begin
        blk(lim + 16'h0001, 1'b1);
        blk(lim, 1'b0);
      end
    end
    // a small code is only reported while the link is active
    @(posedge i_clk);
    i_link_active_control <= 1'b0;
    wr(8'h20, 32'h0000_0000);
    repeat (2) @(posedge i_clk);
    #1 `CHK("code_invalid", 1'b0, o_rec_code_invalid)
    // hard reset mid-run restores the default size code
    @(posedge i_clk);
    i_reset <= 1'b1;
    repeat (6) @(posedge i_clk);
    i_reset <= 1'b0;
    rd(8'h20, 32'h0000_a002);
    `CHK("max_bytes", 16'h0800, o_max_rec_bytes)
    tally_and_finish();
  end
endmodule
